// file: design/fboi_pkg.sv
package fboi_pkg;
  // Output image header byte positions
  localparam int unsigned HDR_SEQ_POS    = 0;
  localparam int unsigned HDR_CTRL_POS   = 1;
  localparam int unsigned HDR_LEN_POS    = 2;
  localparam int unsigned HDR_GAP_POS    = 3;
  localparam int unsigned HDR_TMO_POS    = 4;
  localparam int unsigned HDR_FIX_POS    = 5;
  localparam int unsigned HDR_BYTES      = 6;
  // Control byte fields
  localparam int unsigned CTRL_DC_BIT    = 0;
  localparam int unsigned CTRL_CC_BIT    = 1;
  // Error byte fields
  localparam int unsigned ERR_OFIFO_BIT  = 1;
  localparam int unsigned ERR_IFIFO_BIT  = 2;
  localparam int unsigned ERR_OLOSS_BIT  = 3;
  localparam int unsigned ERR_ILOSS_BIT  = 4;
  // Reset values
  localparam logic [7:0]  SEQ_RST        = 8'h00;
  localparam logic [7:0]  LEN_RST        = 8'h00;
  localparam logic [7:0]  ERR_RST        = 8'h00;
  // Timing: 100 MHz clock, time units of 1 ms and 10 ms
  localparam int unsigned CLK_NS         = 10;
  localparam int unsigned UNIT_SHORT_MS  = 1;
  localparam int unsigned UNIT_LONG_MS   = 10;
  localparam int unsigned MS_CYCLES      = 1000000 / CLK_NS;
  localparam int unsigned UNIT_LONG_MULT = UNIT_LONG_MS / UNIT_SHORT_MS;
  // Transmit activity states
  typedef enum logic [1:0] {
    FBOI_IDLE,
    FBOI_GAP,
    FBOI_SEND
  } fboi_tx_e;
endpackage

// file: design/fboi_tick.sv
`timescale 1ns/1ns
// Millisecond tick divider; a long count is shortened through PERIOD
module fboi_tick #(
  parameter int unsigned PERIOD = fboi_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // Tick out
  output logic      tick_o
);
  logic [31:0] cnt_reg;

  // Free-running divider gives a one-cycle enable every PERIOD cycles
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 32'h0000_0000;
      tick_o  <= 1'b0;
    end else if (cnt_reg == 32'(PERIOD - 1)) begin
      cnt_reg <= 32'h0000_0000;
      tick_o  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
      tick_o  <= 1'b0;
    end
  end
endmodule

// file: design/fboi_core.sv
`timescale 1ns/1ns
// Functional notes
// - New packet only when sequence byte differs from previous image's.
// - Changed sequence byte starts payload forwarding when the sequencer is idle, after any pending interval.
// - Non-unit sequence step still forwards and raises output loss.
// - Same sequence byte forwards nothing, whatever else changed.
// - Diag-clear flag clears all pending diagnostics.
// - Count-clear flag zeroes the receive transfer counter unless a string is published in the same cycle.
// - Length resets to zero; zero length sends no serial bytes.
// - Send exactly length bytes when within the image.
// - Length beyond image size sends only bytes present.
// - Stale image bytes are sent regardless of freshness.
// - Interval byte delays between successive forwarded batches.
// - Silence beyond timeout ends message and publishes it.
// - Timeout setting accepted over 0 to 255.
// - Timeout zero equals one character time.
// - Nonzero timeout scaled by 1 ms or 10 ms unit.
// - Latest image timeout governs all following responses.
// - Timeout held in nonvolatile store, used after power-up.
// - Fixed-length mode publishes when count reaches fixed length.
// - Fixed length byte ignored unless fixed mode enabled.
// - Error byte bits 1..4: fifo overflows and data losses.
// - Counter increments per string moved to master buffer.
module fboi_core
  import fboi_pkg::*;
#(
  parameter int unsigned IMG_MAX   = 128,
  parameter int unsigned MS_PERIOD = fboi_pkg::MS_CYCLES,
  parameter int unsigned CHAR_CYC  = 8681
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // Output image from the fieldbus side, one byte per strobe
  input  wire logic       img_wr_i,
  input  wire logic [6:0] img_addr_i,
  input  wire logic [7:0] img_data_i,
  input  wire logic       img_done_i,
  input  wire logic [7:0] img_size_i,
  // Configuration
  input  wire logic       cfg_unit_10ms_i,
  input  wire logic       cfg_fixed_en_i,
  input  wire logic [7:0] nv_timeout_i,
  // Serial transmit byte stream
  output logic            tx_valid_o,
  output logic [7:0]      tx_data_o,
  input  wire logic       tx_ready_i,
  // Serial receive byte stream and fifo events
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       ofifo_ovf_i,
  input  wire logic       ififo_ovf_i,
  input  wire logic       iloss_i,
  // Status toward the master
  output logic [7:0]      err_o,
  output logic [7:0]      rx_count_o,
  output logic [7:0]      rx_len_o,
  output logic            rx_pub_o,
  output logic            tx_busy_o,
  output logic            nv_we_o,
  output logic [7:0]      nv_timeout_o
);
  logic [7:0] img_mem [IMG_MAX];
  logic [7:0] seq_prev_reg;
  logic       seen_reg;
  logic [7:0] len_reg;
  logic [7:0] gap_reg;
  logic [7:0] tmo_reg;
  logic [7:0] fix_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] seq_tmo;
  logic       new_pkt_reg;
  logic       gap_pkt_reg;
  fboi_tx_e   tx_state_reg;
  logic [7:0] tx_idx_reg;
  logic [7:0] tx_end_reg;
  logic [7:0] gap_cnt_reg;
  logic       gap_pend_reg;
  logic [7:0] rx_cnt_reg;
  logic [7:0] sil_ms_reg;
  logic [31:0] sil_cyc_reg;
  logic       rx_act_reg;
  logic       ms_tick;
  logic [7:0] seq_in;
  logic [7:0] avail;
  logic [15:0] tmo_ms;
  logic       sil_done;
  logic       fix_done;
  logic       publish;

  fboi_tick #(
    .PERIOD (MS_PERIOD)
  ) u_tick (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .tick_o    (ms_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Image capture; payload bytes stay until overwritten
  always_ff @(posedge sys_clk_i) begin
    if (img_wr_i && img_addr_i >= 7'(HDR_BYTES)) begin
      img_mem[img_addr_i] <= img_data_i;
    end
  end

  // Header bytes of the image being written
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      seq_in   <= SEQ_RST;
      ctrl_reg <= 8'h00;
      len_reg  <= LEN_RST;
      gap_reg  <= 8'h00;
      fix_reg  <= 8'h00;
    end else if (img_wr_i) begin
      case (img_addr_i)
        7'(HDR_SEQ_POS):  seq_in   <= img_data_i;
        7'(HDR_CTRL_POS): ctrl_reg <= img_data_i;
        7'(HDR_LEN_POS):  len_reg  <= img_data_i;
        7'(HDR_GAP_POS):  gap_reg  <= img_data_i;
        7'(HDR_FIX_POS):  fix_reg  <= img_data_i;
        default:          ;
      endcase
    end
  end

  // Timeout follows the latest image; power-up value comes from nv store
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      tmo_reg      <= 8'h00;
      seen_reg     <= 1'b0;
      nv_we_o      <= 1'b0;
      nv_timeout_o <= 8'h00;
    end else begin
      nv_we_o <= 1'b0;
      if (!seen_reg) begin
        tmo_reg <= nv_timeout_i;
      end
      if (img_done_i) begin
        seen_reg     <= 1'b1;
        tmo_reg      <= seq_tmo;
        nv_we_o      <= 1'b1;
        nv_timeout_o <= seq_tmo;
      end
    end
  end

  // Timeout byte latch feeding the store
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      seq_tmo <= 8'h00;
    end else if (img_wr_i && img_addr_i == 7'(HDR_TMO_POS)) begin
      seq_tmo <= img_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // New packet detection on image completion
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      seq_prev_reg <= SEQ_RST;
      new_pkt_reg  <= 1'b0;
      gap_pkt_reg  <= 1'b0;
    end else begin
      new_pkt_reg <= 1'b0;
      gap_pkt_reg <= 1'b0;
      if (img_done_i) begin
        seq_prev_reg <= seq_in;
        // First image only sets the reference
        if (seen_reg && seq_in != seq_prev_reg) begin
          new_pkt_reg <= 1'b1;
          gap_pkt_reg <= (seq_in != 8'(seq_prev_reg + 8'h01));
        end
      end
    end
  end

  // Bytes present: image size minus header, zero when the image is no larger than the header
  always_comb begin
    avail = (img_size_i > 8'(HDR_BYTES)) ? 8'(img_size_i - 8'(HDR_BYTES))
                                         : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit sequencer with inter-batch gap
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      tx_state_reg <= FBOI_IDLE;
      tx_idx_reg   <= 8'h00;
      tx_end_reg   <= 8'h00;
      gap_cnt_reg  <= 8'h00;
      gap_pend_reg <= 1'b0;
      tx_valid_o   <= 1'b0;
      tx_data_o    <= 8'h00;
      tx_busy_o    <= 1'b0;
    end else begin
      case (tx_state_reg)
        FBOI_IDLE: begin
          tx_valid_o <= 1'b0;
          if (new_pkt_reg && len_reg != 8'h00) begin
            tx_idx_reg <= 8'h00;
            tx_end_reg <= (len_reg > avail) ? avail : len_reg;
            gap_cnt_reg <= gap_reg;
            tx_busy_o  <= 1'b1;
            tx_state_reg <= (gap_pend_reg && gap_reg != 8'h00) ? FBOI_GAP
                                                             : FBOI_SEND;
          end else begin
            tx_busy_o <= 1'b0;
          end
        end
        FBOI_GAP: begin
          // Interval counted in ms ticks between batches
          if (ms_tick) begin
            gap_cnt_reg <= gap_cnt_reg - 8'h01;
            if (gap_cnt_reg == 8'h01) begin
              tx_state_reg <= FBOI_SEND;
            end
          end
        end
        FBOI_SEND: begin
          if (!tx_valid_o || tx_ready_i) begin
            if (tx_idx_reg < tx_end_reg) begin
              tx_valid_o <= 1'b1;
              tx_data_o  <= img_mem[7'(tx_idx_reg + 8'(HDR_BYTES))];
              tx_idx_reg <= tx_idx_reg + 8'h01;
            end else begin
              tx_valid_o   <= 1'b0;
              gap_pend_reg <= 1'b1;
              tx_state_reg <= FBOI_IDLE;
            end
          end
        end
        default: tx_state_reg <= FBOI_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive timeout: zero means one character time, else scaled ms
  always_comb begin
    // Widen before the product so 255 x 10 does not wrap at eight bits
    tmo_ms = cfg_unit_10ms_i ? 16'(tmo_reg) * 16'(UNIT_LONG_MULT)
                             : {8'h00, tmo_reg};
    sil_done = rx_act_reg && !rx_valid_i &&
               ((tmo_reg == 8'h00) ? (sil_cyc_reg >= 32'(CHAR_CYC))
                                   : ({8'h00, sil_ms_reg} >= tmo_ms[15:0]
                                      && tmo_ms[15:8] == 8'h00) ||
                                     (tmo_ms[15:8] != 8'h00 &&
                                      sil_cyc_reg >= 32'(tmo_ms) *
                                      32'(MS_PERIOD)));
    fix_done = cfg_fixed_en_i && fix_reg != 8'h00 && rx_valid_i &&
               8'(rx_cnt_reg + 8'h01) == fix_reg;
    publish  = sil_done || fix_done;
  end

  // Silence counters restart on every received byte except the one that completes a fixed length
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sil_cyc_reg <= 32'h0000_0000;
      sil_ms_reg  <= 8'h00;
      rx_act_reg  <= 1'b0;
      rx_cnt_reg  <= 8'h00;
    end else if (rx_valid_i && !fix_done) begin
      sil_cyc_reg <= 32'h0000_0000;
      sil_ms_reg  <= 8'h00;
      rx_act_reg  <= 1'b1;
      rx_cnt_reg  <= rx_cnt_reg + 8'h01;
    end else if (publish) begin
      rx_act_reg  <= 1'b0;
      rx_cnt_reg  <= 8'h00;
    end else if (rx_act_reg) begin
      sil_cyc_reg <= sil_cyc_reg + 32'h0000_0001;
      if (ms_tick && sil_ms_reg != 8'hFF) begin
        sil_ms_reg <= sil_ms_reg + 8'h01;
      end
    end
  end

  // Publish strobe, length and transfer counter
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rx_pub_o   <= 1'b0;
      rx_len_o   <= 8'h00;
      rx_count_o <= 8'h00;
    end else begin
      rx_pub_o <= publish;
      if (publish) begin
        rx_len_o <= fix_done ? fix_reg : rx_cnt_reg;
      end
      // Clear loses to a simultaneous increment so no string goes uncounted
      if (publish) begin
        rx_count_o <= rx_count_o + 8'h01;
      end else if (img_done_i && ctrl_reg[CTRL_CC_BIT]) begin
        rx_count_o <= 8'h00;
      end
    end
  end

  // Sticky diagnostics; a new event wins over the clear
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      err_o <= ERR_RST;
    end else begin
      if (img_done_i && ctrl_reg[CTRL_DC_BIT]) begin
        err_o <= ERR_RST;
      end
      if (ofifo_ovf_i) err_o[ERR_OFIFO_BIT] <= 1'b1;
      if (ififo_ovf_i) err_o[ERR_IFIFO_BIT] <= 1'b1;
      if (gap_pkt_reg) err_o[ERR_OLOSS_BIT] <= 1'b1;
      if (iloss_i)     err_o[ERR_ILOSS_BIT] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  AST_GAP_LOSS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    gap_pkt_reg |=> err_o[ERR_OLOSS_BIT])
    else $error("loss flag not raised");
  AST_SAME_SEQ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    img_done_i && seq_in == seq_prev_reg |=> !new_pkt_reg)
    else $error("repeat sequence forwarded");
  AST_ZERO_LEN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tx_state_reg == FBOI_IDLE && new_pkt_reg && len_reg == 8'h00
    |=> tx_state_reg == FBOI_IDLE)
    else $error("zero length started send");
  AST_CLAMP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tx_end_reg <= avail)
    else $error("send end beyond image");
  AST_CNT_INC: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    publish |=> rx_count_o == 8'($past(rx_count_o) + 8'h01))
    else $error("counter not incremented");
  AST_CNT_CLR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    img_done_i && ctrl_reg[CTRL_CC_BIT] && !publish |=> rx_count_o == 8'h00)
    else $error("counter not cleared");
  AST_DIAG_CLR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    img_done_i && ctrl_reg[CTRL_DC_BIT] && !ofifo_ovf_i && !ififo_ovf_i &&
    !gap_pkt_reg && !iloss_i |=> err_o == 8'h00)
    else $error("diagnostics not cleared");
  AST_START: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tx_state_reg == FBOI_IDLE && new_pkt_reg && len_reg != 8'h00
    |=> tx_busy_o)
    else $error("new packet not started");
  AST_FIX_IGN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !cfg_fixed_en_i |-> !fix_done)
    else $error("fixed length used while disabled");
endmodule

// file: testbench/fboi_master_model.sv
`timescale 1ns/1ns
//////////////////////////////////////////
// Fieldbus master: writes cyclic output images one byte a cycle
module fboi_master_model (
  // Clock
  input  wire logic       sys_clk_i,
  // Output image toward the block
  output logic            img_wr_o,
  output logic [6:0]      img_addr_o,
  output logic [7:0]      img_data_o,
  output logic            img_done_o
);
  logic [7:0] last_seq;
  logic [7:0] mem [0:127];

  // Idle bus at time zero
  initial begin
    img_wr_o   = 1'b0;
    img_addr_o = 7'h00;
    img_data_o = 8'h00;
    img_done_o = 1'b0;
    last_seq   = 8'h00;
  end

  // One byte write, kept as the record of what the image holds
  task automatic put(input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    img_wr_o   <= 1'b1;
    img_addr_o <= a;
    img_data_o <= d;
    mem[a] = d;
  endtask

  // Header and payload; a step other than one is only a test's choice
  task automatic send_img(input logic [7:0] step, c, l, g, t, f,
                          input int np, input logic [7:0] base);
    last_seq = last_seq + step;
    put(7'h00, last_seq);
    put(7'h01, c & 8'h03);
    put(7'h02, l);
    put(7'h03, g);
    put(7'h04, t);
    put(7'h05, f);
    for (int i = 0; i < np; i++) begin
      put(7'(6 + i), base + 8'(i));
    end
    // Released data turns over so it never looks held
    @(posedge sys_clk_i);
    img_wr_o   <= 1'b0;
    img_data_o <= ~img_data_o;
    img_done_o <= 1'b1;
    @(posedge sys_clk_i);
    img_done_o <= 1'b0;
  endtask
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ns
module tb;
  import fboi_pkg::*;
  localparam int unsigned MSP = 10;
  localparam int unsigned CHC = 20;
  logic       sys_clk_i, rst_n_i, img_wr, img_done, tx_ready_i, stall;
  logic       cfg_unit_10ms_i, cfg_fixed_en_i, rx_valid_i;
  logic       ofifo_ovf_i, ififo_ovf_i, iloss_i;
  logic       tx_valid_o, tx_busy_o, rx_pub_o, nv_we_o;
  logic [6:0] img_addr;
  logic [7:0] img_data, img_size_i, nv_timeout_i, rx_data_i, nv_last;
  logic [7:0] tx_data_o, err_o, rx_count_o, rx_len_o, nv_timeout_o;
  logic [7:0] exp_cnt, base;
  logic [7:0] txq [$];
  int         n_fail, tests_run, lat;

  //////////////////////////////////////////
  // Short ms and character counts keep the run brief
  fboi_core #(.MS_PERIOD(MSP), .CHAR_CYC(CHC)) fboi_core_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .img_wr_i(img_wr),
    .img_addr_i(img_addr), .img_data_i(img_data), .img_done_i(img_done),
    .img_size_i(img_size_i), .cfg_unit_10ms_i(cfg_unit_10ms_i),
    .cfg_fixed_en_i(cfg_fixed_en_i), .nv_timeout_i(nv_timeout_i),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_ready_i(tx_ready_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .ofifo_ovf_i(ofifo_ovf_i),
    .ififo_ovf_i(ififo_ovf_i), .iloss_i(iloss_i), .err_o(err_o),
    .rx_count_o(rx_count_o), .rx_len_o(rx_len_o), .rx_pub_o(rx_pub_o),
    .tx_busy_o(tx_busy_o), .nv_we_o(nv_we_o),
    .nv_timeout_o(nv_timeout_o));

  fboi_master_model fboi_master_model_inst (
    .sys_clk_i(sys_clk_i), .img_wr_o(img_wr), .img_addr_o(img_addr),
    .img_data_o(img_data), .img_done_o(img_done));

  // Clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Sink stalls every other cycle when asked; logs bytes and nv writes
  always @(posedge sys_clk_i) begin
    tx_ready_i <= stall ? ~tx_ready_i : 1'b1;
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) txq.push_back(tx_data_o);
    if (nv_we_o === 1'b1) nv_last <= nv_timeout_o;
  end

  //////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Send one image, note latency to the first byte, wait out the batch
  task automatic img(input int st, c, l, g, t, f, np);
    txq.delete();
    base = base + 8'h11;
    fboi_master_model_inst.send_img(8'(st), 8'(c), 8'(l), 8'(g), 8'(t),
                                    8'(f), np, base);
    lat = 0;
    while (tx_valid_o !== 1'b1 && lat < 60) begin
      @(negedge sys_clk_i);
      lat++;
    end
    for (int i = 0; i < 3000 && tx_busy_o !== 1'b0; i++) begin
      @(negedge sys_clk_i);
    end
  endtask

  task automatic chk_tx(input int n);
    chk(txq.size(), n);
    for (int i = 0; i < n && i < txq.size(); i++) begin
      chk(txq[i], fboi_master_model_inst.mem[6 + i]);
    end
  endtask

  // Serial bytes, then the silence until the string is published
  task automatic rx_case(input int n, lo, hi);
    int cnt;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      rx_valid_i <= 1'b1;
      rx_data_i  <= base + 8'(i);
      @(posedge sys_clk_i);
      rx_valid_i <= 1'b0;
    end
    cnt = 0;
    while (rx_pub_o !== 1'b1 && cnt < 30000) begin
      @(negedge sys_clk_i);
      cnt++;
    end
    chk(32'(cnt >= lo && cnt <= hi), 1);
    @(negedge sys_clk_i);
    exp_cnt = exp_cnt + 8'h01;
    chk(rx_len_o, n);
    chk(rx_count_o, exp_cnt);
  endtask

  //////////////////////////////////////////
  task automatic t_power();
    rx_case(2, MSP, 3 * MSP + 6);
    $display("test power done");
  endtask

  task automatic t_seq();
    img(5, 0, 2, 0, 0, 0, 2);
    chk(txq.size(), 0);
    chk(err_o, 8'h00);
    img(1, 0, 2, 0, 0, 0, 2);
    chk(lat, 3);
    chk_tx(2);
    chk(err_o, 8'h00);
    img(0, 0, 3, 0, 0, 0, 3);
    chk(txq.size(), 0);
    $display("test sequence done");
  endtask

  task automatic t_diag();
    stall = 1'b1;
    img(2, 0, 3, 0, 0, 0, 3);
    stall = 1'b0;
    chk_tx(3);
    chk(err_o, 8'h08);
    @(posedge sys_clk_i);
    ofifo_ovf_i <= 1'b1;
    ififo_ovf_i <= 1'b1;
    iloss_i     <= 1'b1;
    @(posedge sys_clk_i);
    ofifo_ovf_i <= 1'b0;
    ififo_ovf_i <= 1'b0;
    iloss_i     <= 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk(err_o, 8'h1e);
    img(1, 1, 1, 0, 0, 0, 1);
    chk(err_o, 8'h00);
    $display("test diagnostics done");
  endtask

  task automatic t_len();
    img(1, 0, 0, 0, 0, 0, 2);
    chk(txq.size(), 0);
    @(posedge sys_clk_i);
    img_size_i <= 8'h0a;
    img(1, 0, 200, 0, 0, 0, 4);
    chk_tx(4);
    @(posedge sys_clk_i);
    img_size_i <= 8'h80;
    img(1, 0, 4, 0, 0, 0, 1);
    chk_tx(4);
    img(1, 0, 1, 3, 0, 0, 1);
    // Free-running ms tick: three ticks take between two and three ms
    chk(32'(lat > 2 * MSP + 2 && lat <= 4 * MSP + 8), 1);
    $display("test length done");
  endtask

  task automatic t_rx();
    img(1, 0, 1, 0, 0, 0, 1);
    rx_case(3, CHC - 1, CHC + 4);
    rx_case(1, CHC - 1, CHC + 4);
    img(1, 0, 1, 0, 255, 0, 1);
    chk(nv_last, 8'hff);
    rx_case(2, 254 * MSP, 256 * MSP + 6);
    @(posedge sys_clk_i);
    cfg_unit_10ms_i <= 1'b1;
    img(1, 0, 1, 0, 1, 0, 1);
    rx_case(1, 9 * MSP, 11 * MSP + 6);
    @(posedge sys_clk_i);
    cfg_unit_10ms_i <= 1'b0;
    cfg_fixed_en_i  <= 1'b1;
    img(1, 0, 1, 0, 255, 4, 1);
    rx_case(4, 0, 3);
    @(posedge sys_clk_i);
    cfg_fixed_en_i <= 1'b0;
    img(1, 0, 1, 0, 0, 4, 1);
    rx_case(4, CHC - 1, CHC + 4);
    img(1, 2, 1, 0, 0, 0, 1);
    exp_cnt = 8'h00;
    chk(rx_count_o, 8'h00);
    $display("test receive done");
  endtask

  //////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n_i         = 1'b0;
    stall           = 1'b0;
    tx_ready_i      = 1'b1;
    img_size_i      = 8'h80;
    cfg_unit_10ms_i = 1'b0;
    cfg_fixed_en_i  = 1'b0;
    nv_timeout_i    = 8'h02;
    rx_valid_i      = 1'b0;
    rx_data_i       = 8'h00;
    ofifo_ovf_i     = 1'b0;
    ififo_ovf_i     = 1'b0;
    iloss_i         = 1'b0;
    exp_cnt         = 8'h00;
    nv_last         = 8'h5a;
    base            = 8'h00;
    n_fail          = 0;
    tests_run       = 0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_power();
    t_seq();
    t_diag();
    t_len();
    t_rx();
    report_and_stop();
  end

  // Watchdog well past the expected run of some three thousand cycles
  initial begin
    #400000;
    n_fail++;
    report_and_stop();
  end
endmodule
